// ### verilog/sfe_front_end.sv
// Serial flash command front end: frames, decodes and phases host commands.
// Assumes chip select, serial clock and data pins arrive asynchronously;
// the serial clock runs far slower than clk_sys (eight samples or more).
// Contract
// RULE1: Only modes 0 and 3; sample on rising clock, drive on falling.
// RULE2: Dual-output read drives input and output lines in data phase only.
// RULE3: Dual I/O carries opcode on one line, address and data on two.
// RULE4: Quad-output read drives all four data pins as outputs.
// RULE5: Quad I/O keeps pins inputs for address, outputs for data.
// RULE6: Host selects, sends 8-bit opcode then fields; deselect ends it.
// RULE7: Every byte moves most significant bit first.
// RULE8: Unsupported opcode starts nothing; input ignored until reselect.
// RULE9: Deselect before opcode and address complete does nothing, back to idle.
// RULE10: Three address bytes received; top address bit discarded.
// RULE11: Reset arm and reset execute are opcode-only.
// RULE12: Deep-sleep enter and leave are opcode-only.
// RULE13: Plain read has no dummy; fast read has eight dummy clocks.
// RULE14: Dual-output read: one-line address, eight dummies, two-line data.
// RULE15: Dual I/O read: two-line address, four mode clocks, continuous form.
// RULE16: Quad-output read: one-line address, eight dummies, four-line data.
// RULE17: Quad I/O read: two mode clocks, four dummies, continuous form.
// RULE18: Quad word read: like quad I/O but two dummy clocks.
// RULE19: Wrap setup: no address, six dummies, one four-line byte in.
// RULE20: Write permit set and clear are opcode-only.
// RULE21: Volatile status write permit is opcode-only.
// RULE22: Page program one-line data; quad page program four-line data.
// RULE23: Phase clocks follow line count: 8/24/8 at one line, scaled.
// RULE24: Continuous mode byte is a parameter; else expect an opcode.
module sfe_front_end import sfe_pkg::*; #(
  parameter logic [7:0] CONT_MODE = MODE_CONT
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Flash pins, io0 input line, io1 output line
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // Decoded command
  output sfe_cmd_t cmd,
  output logic cmd_valid,
  // Read data source
  output logic tx_req,
  input wire logic [7:0] tx_data,
  // Write data sink
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  output logic rx_overrun
);

  // ************************************************************
  // Helpers
  // ************************************************************
  // RULE23 address clocks
  function automatic logic [5:0] addr_clk(input logic [2:0] ln);
    addr_clk = (ln == LN4) ? ADDR_CLK4 : (ln == LN2) ? ADDR_CLK2 : ADDR_CLK1;
  endfunction

  // RULE23 byte clocks
  function automatic logic [5:0] byte_clk(input logic [2:0] ln);
    byte_clk = (ln == LN4) ? BYTE_CLK4 : (ln == LN2) ? BYTE_CLK2 : BYTE_CLK1;
  endfunction

  // RULE7 MSB-first shift; RULE3 two lines, io1 carries the higher bit
  function automatic logic [23:0] shin(input logic [23:0] s, input logic [2:0] ln,
                                       input logic [3:0] io);
    if (ln == LN4) shin = {s[19:0], io};
    else if (ln == LN2) shin = {s[21:0], io[1:0]};
    else shin = {s[22:0], io[0]};
  endfunction

  // Opcode table
  function automatic sfe_dec_t decode(input logic [7:0] op);
    sfe_dec_t d;
    d = '0;
    d.ok = 1'b1;
    case (op)
      // RULE11 RULE12 RULE20 RULE21 opcode only
      OP_RST_ARM, OP_RST_GO, OP_SLEEP, OP_WAKE, OP_WEN, OP_WDIS, OP_VWEN: ;
      // RULE13 plain read
      OP_READ: begin
        d.alines = LN1; d.dlines = LN1; d.dout = 1'b1;
      end
      // RULE13 fast read
      OP_FREAD: begin
        d.alines = LN1; d.dclk = DUM_FAST; d.dlines = LN1; d.dout = 1'b1;
      end
      // RULE14 dual output
      OP_DREAD: begin
        d.alines = LN1; d.dclk = DUM_FAST; d.dlines = LN2; d.dout = 1'b1;
      end
      // RULE15 dual I/O
      OP_DIO: begin
        d.alines = LN2; d.mclk = MCLK_DIO; d.dlines = LN2; d.dout = 1'b1;
      end
      // RULE16 quad output
      OP_QREAD: begin
        d.alines = LN1; d.dclk = DUM_FAST; d.dlines = LN4; d.dout = 1'b1;
      end
      // RULE17 quad I/O
      OP_QIO: begin
        d.alines = LN4; d.mclk = MCLK_QIO; d.dclk = DUM_QIO;
        d.dlines = LN4; d.dout = 1'b1;
      end
      // RULE18 quad word read
      OP_QWORD: begin
        d.alines = LN4; d.mclk = MCLK_QIO; d.dclk = DUM_QWORD;
        d.dlines = LN4; d.dout = 1'b1;
      end
      // RULE19 wrap setup byte
      OP_WRAP: begin
        d.dclk = DUM_WRAP; d.dlines = LN4;
      end
      // RULE22 page programs
      OP_PROG: begin
        d.alines = LN1; d.dlines = LN1;
      end
      OP_QPROG: begin
        d.alines = LN1; d.dlines = LN4;
      end
      // RULE8 anything else is refused
      default: d.ok = 1'b0;
    endcase
    decode = d;
  endfunction

  function automatic sfe_st_t data_st(input sfe_dec_t d);
    if (d.dlines == LN0) data_st = ST_DONE;
    else if (d.dout) data_st = ST_DOUT;
    else data_st = ST_DIN;
  endfunction

  function automatic sfe_st_t after_mode(input sfe_dec_t d);
    after_mode = (d.dclk != 6'd0) ? ST_DUM : data_st(d);
  endfunction

  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic sck_d;
  logic cs_s;
  logic sck_s;
  logic [3:0] io_s;
  logic rise;
  logic fall;

  // Two stages per pin; sync1 feeds sync2 alone
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      sck_d <= 1'b0;
    end else begin
      sync1 <= {cs_n, sck, io_in};
      sync2 <= sync1;
      sck_d <= sync2[4];
    end
  end

  assign cs_s = sync2[5];
  assign sck_s = sync2[4];
  assign io_s = sync2[3:0];
  // RULE1 sample on rise, drive on fall, only while selected
  assign rise = !cs_s && sck_s && !sck_d;
  assign fall = !cs_s && !sck_s && sck_d;

  // ************************************************************
  // Phase sequencer
  // ************************************************************
  sfe_st_t st;
  sfe_st_t next_st;
  sfe_dec_t dec;
  sfe_dec_t dnew;
  logic [5:0] cnt;
  logic [5:0] len;
  logic [2:0] lines_now;
  logic [23:0] sh;
  logic [23:0] sh_nx;
  logic last;
  logic cont;

  // Phase length and line count of the current phase
  always_comb begin
    lines_now = LN1;
    len = OPC_CLK;
    case (st)
      ST_ADDR: begin
        lines_now = dec.alines;
        len = addr_clk(dec.alines);
      end
      ST_MODE: begin
        lines_now = dec.alines;
        len = {3'd0, dec.mclk};
      end
      ST_DUM: len = dec.dclk;
      ST_DIN: begin
        lines_now = dec.dlines;
        len = byte_clk(dec.dlines);
      end
      default: ;
    endcase
  end

  assign last = (cnt == len - 6'd1);
  assign sh_nx = shin(sh, lines_now, io_s);
  assign dnew = decode(sh_nx[7:0]);

  // Next phase
  always_comb begin
    next_st = st;
    // RULE9 deselect always returns to idle
    if (cs_s) begin
      next_st = ST_IDLE;
    end else begin
      unique case (st)
        // RULE24 opcode expected unless continuous mode is on
        ST_IDLE: next_st = cont ? ST_ADDR : ST_OPC;
        ST_OPC: begin
          if (rise && last) begin
            // RULE8 refused opcode parks until reselect
            if (!dnew.ok) next_st = ST_IGN;
            else if (dnew.alines != LN0) next_st = ST_ADDR;
            else next_st = after_mode(dnew);
          end
        end
        ST_ADDR: begin
          if (rise && last) next_st = (dec.mclk != 3'd0) ? ST_MODE : after_mode(dec);
        end
        ST_MODE: if (rise && last) next_st = after_mode(dec);
        ST_DUM: if (rise && last) next_st = data_st(dec);
        ST_DIN, ST_DOUT, ST_DONE, ST_IGN: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) st <= ST_IDLE;
    else st <= next_st;
  end

  // Clock counter, restarts on every phase change and on each write-data byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) cnt <= 6'd0;
    else if (st != next_st) cnt <= 6'd0;
    else if (rise) cnt <= (st == ST_DIN && last) ? 6'd0 : cnt + 6'd1;
  end

  // Shift register; the latest bits always sit at the bottom
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) sh <= 24'h000000;
    else if (rise && (st == ST_OPC || st == ST_ADDR || st == ST_MODE || st == ST_DIN))
      sh <= sh_nx;
  end

  // Decode is kept across deselect for the continuous form
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) dec <= '0;
    else if (st == ST_OPC && rise && last) dec <= dnew;
  end

  // RULE24 continuous mode only from the parameter mode byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) cont <= 1'b0;
    else if (st == ST_MODE && rise && last) cont <= (sh_nx[7:0] == CONT_MODE);
  end

  // ************************************************************
  // Command report
  // ************************************************************
  // Fields fill in as their phases close
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd <= '0;
    end else if (rise && last) begin
      if (st == ST_OPC) begin
        cmd.opcode <= sh_nx[7:0];
        cmd.mode <= 8'h00;
        cmd.cont <= 1'b0;
      end
      // RULE10 top address bit dropped
      if (st == ST_ADDR) cmd.addr <= sh_nx[22:0];
      if (st == ST_MODE) begin
        cmd.mode <= sh_nx[7:0];
        cmd.cont <= (sh_nx[7:0] == CONT_MODE);
      end
    end
  end

  // RULE9 reported only once opcode and address are complete
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) cmd_valid <= 1'b0;
    else cmd_valid <= (st == ST_OPC || st == ST_ADDR || st == ST_MODE) &&
                      (next_st == ST_DUM || next_st == ST_DIN ||
                       next_st == ST_DOUT || next_st == ST_DONE);
  end

  // ************************************************************
  // Write data path
  // ************************************************************
  logic rx_push;
  logic [7:0] rx_byte;
  logic buf_ready;

  // One byte per completed data group
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_push <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_push <= rise && last && st == ST_DIN;
      rx_byte <= sh_nx[7:0];
    end
  end

  // The host cannot be paused, so a full buffer is flagged, not hidden
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) rx_overrun <= 1'b0;
    else if (rx_push && !buf_ready) rx_overrun <= 1'b1;
    else if (st == ST_IDLE && !cs_s) rx_overrun <= 1'b0;
  end

  sfe_buf2 #(.W(BUF_W)) u_rx_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(rx_push),
    .in_ready(buf_ready),
    .in_data(rx_byte),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // ************************************************************
  // Read data path and pin drive
  // ************************************************************
  logic [7:0] out_sh;
  logic [5:0] out_left;
  logic [3:0] oe_lines;

  // RULE2 RULE4 enables chosen by data line count
  assign oe_lines = (dec.dlines == LN4) ? OE_X4 : (dec.dlines == LN2) ? OE_X2 : OE_X1;

  // RULE5 pins released outside data phase; RULE1 change on falling edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
      out_sh <= 8'h00;
      out_left <= 6'd0;
    end else if (cs_s || st != ST_DOUT) begin
      io_oe <= 4'h0;
      out_left <= 6'd0;
    end else if (fall) begin
      io_oe <= oe_lines;
      if (out_left == 6'd0) begin
        out_left <= byte_clk(dec.dlines) - 6'd1;
        if (dec.dlines == LN4) begin
          io_out <= tx_data[7:4];
          out_sh <= {tx_data[3:0], 4'h0};
        end else if (dec.dlines == LN2) begin
          io_out <= {2'b00, tx_data[7:6]};
          out_sh <= {tx_data[5:0], 2'b00};
        end else begin
          io_out <= {2'b00, tx_data[7], 1'b0};
          out_sh <= {tx_data[6:0], 1'b0};
        end
      end else begin
        out_left <= out_left - 6'd1;
        if (dec.dlines == LN4) begin
          io_out <= out_sh[7:4];
          out_sh <= {out_sh[3:0], 4'h0};
        end else if (dec.dlines == LN2) begin
          io_out <= {2'b00, out_sh[7:6]};
          out_sh <= {out_sh[5:0], 2'b00};
        end else begin
          io_out <= {2'b00, out_sh[7], 1'b0};
          out_sh <= {out_sh[6:0], 1'b0};
        end
      end
    end
  end

  // RULE13 next byte asked for on entry and at each byte load
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) tx_req <= 1'b0;
    else tx_req <= (st != ST_DOUT && next_st == ST_DOUT) ||
                   (fall && st == ST_DOUT && out_left == 6'd0);
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_idle_quiet;
    cs_s |=> (st == ST_IDLE && io_oe == 4'h0 && !cmd_valid);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("active after deselect"); // RULE9

  property p_addr_in;
    (st == ST_ADDR || st == ST_MODE || st == ST_DUM) |-> io_oe == 4'h0;
  endproperty
  a_addr_in: assert property (p_addr_in) else $error("pins driven before data"); // RULE5

  property p_quad_oe;
    (st == ST_DOUT && dec.dlines == LN4 && io_oe != 4'h0) |-> io_oe == OE_X4;
  endproperty
  a_quad_oe: assert property (p_quad_oe) else $error("quad enables wrong"); // RULE4

  property p_dual_oe;
    (st == ST_DOUT && dec.dlines == LN2 && io_oe != 4'h0) |-> io_oe == OE_X2;
  endproperty
  a_dual_oe: assert property (p_dual_oe) else $error("dual enables wrong"); // RULE2

  property p_drive_fall;
    $changed(io_out) |-> $past(fall);
  endproperty
  a_drive_fall: assert property (p_drive_fall) else $error("output moved off edge"); // RULE1

  property p_ign_silent;
    st == ST_IGN |=> ((st == ST_IGN || st == ST_IDLE) && !cmd_valid && !tx_req);
  endproperty
  a_ign_silent: assert property (p_ign_silent) else $error("refused opcode acted"); // RULE8

  property p_opc_first;
    (st == ST_IDLE && !cs_s && !cont) |=> st == ST_OPC;
  endproperty
  a_opc_first: assert property (p_opc_first) else $error("opcode phase skipped"); // RULE24

  property p_cont_skip;
    (st == ST_IDLE && !cs_s && cont) |=> st == ST_ADDR;
  endproperty
  a_cont_skip: assert property (p_cont_skip) else $error("continuous form missed"); // RULE15

  property p_addr_len;
    st == ST_ADDR |-> cnt < addr_clk(dec.alines);
  endproperty
  a_addr_len: assert property (p_addr_len) else $error("address phase too long"); // RULE23

  property p_tx_first;
    $rose(st == ST_DOUT) |-> tx_req;
  endproperty
  a_tx_first: assert property (p_tx_first) else $error("no first byte request"); // RULE13

  c_quad_out: cover property (st == ST_DOUT && dec.dlines == LN4 && fall);
  c_cont_entry: cover property (st == ST_IDLE && !cs_s && cont);
  c_prog_byte: cover property (rx_push);
  c_refused: cover property (st == ST_IGN);

endmodule // sfe_front_end

// ### verilog/sfe_pkg.sv
// Shared constants and types of the serial flash command front end.
// Assumes one system clock domain; the serial link is sampled, not clocked.
package sfe_pkg;

  // ************************************************************
  // Opcodes
  // ************************************************************
  localparam logic [7:0] OP_RST_ARM = 8'h66;
  localparam logic [7:0] OP_RST_GO = 8'h99;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0b;
  localparam logic [7:0] OP_DREAD = 8'h3b;
  localparam logic [7:0] OP_DIO = 8'hbb;
  localparam logic [7:0] OP_QREAD = 8'h6b;
  localparam logic [7:0] OP_QIO = 8'heb;
  localparam logic [7:0] OP_QWORD = 8'he7;
  localparam logic [7:0] OP_WRAP = 8'h77;
  localparam logic [7:0] OP_WEN = 8'h06;
  localparam logic [7:0] OP_VWEN = 8'h50;
  localparam logic [7:0] OP_WDIS = 8'h04;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_QPROG = 8'h32;
  // Mode byte that keeps continuous reading on (default value only)
  localparam logic [7:0] MODE_CONT = 8'ha0;

  // ************************************************************
  // Lines, clock counts and pin enables
  // ************************************************************
  localparam logic [2:0] LN0 = 3'd0;
  localparam logic [2:0] LN1 = 3'd1;
  localparam logic [2:0] LN2 = 3'd2;
  localparam logic [2:0] LN4 = 3'd4;
  localparam logic [5:0] OPC_CLK = 6'd8;
  localparam logic [5:0] ADDR_CLK1 = 6'd24;
  localparam logic [5:0] ADDR_CLK2 = 6'd12;
  localparam logic [5:0] ADDR_CLK4 = 6'd6;
  localparam logic [5:0] BYTE_CLK1 = 6'd8;
  localparam logic [5:0] BYTE_CLK2 = 6'd4;
  localparam logic [5:0] BYTE_CLK4 = 6'd2;
  localparam logic [2:0] MCLK_DIO = 3'd4;
  localparam logic [2:0] MCLK_QIO = 3'd2;
  localparam logic [5:0] DUM_FAST = 6'd8;
  localparam logic [5:0] DUM_QIO = 6'd4;
  localparam logic [5:0] DUM_QWORD = 6'd2;
  localparam logic [5:0] DUM_WRAP = 6'd6;
  localparam logic [3:0] OE_X1 = 4'h2;
  localparam logic [3:0] OE_X2 = 4'h3;
  localparam logic [3:0] OE_X4 = 4'hf;
  localparam logic [5:0] SYNC_RST = 6'h20;
  localparam int BUF_W = 8;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic ok;
    logic [2:0] alines;
    logic [2:0] mclk;
    logic [5:0] dclk;
    logic [2:0] dlines;
    logic dout;
  } sfe_dec_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [22:0] addr;
    logic [7:0] mode;
    logic cont;
  } sfe_cmd_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_OPC = 9'h002,
    ST_ADDR = 9'h004,
    ST_MODE = 9'h008,
    ST_DUM = 9'h010,
    ST_DIN = 9'h020,
    ST_DOUT = 9'h040,
    ST_DONE = 9'h080,
    ST_IGN = 9'h100
  } sfe_st_t;

endpackage

// ### verilog/sfe_buf2.sv
// Two-entry valid/ready buffer with registered outputs.
// Assumes producer and consumer share clk_sys.
module sfe_buf2 import sfe_pkg::*; #(
  parameter int W = BUF_W
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] spare;
  logic spare_v;
  logic push;
  logic pop;

  // Full only when the spare slot holds a word
  assign in_ready = !spare_v;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Head feeds the port, spare catches a word during a stall
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
      spare <= '0;
      spare_v <= 1'b0;
    end else if (!out_valid || pop) begin
      if (spare_v) begin
        out_data <= spare;
        out_valid <= 1'b1;
        spare_v <= push;
        if (push) spare <= in_data;
      end else begin
        out_data <= in_data;
        out_valid <= push;
      end
    end else if (push) begin
      spare <= in_data;
      spare_v <= 1'b1;
    end
  end
endmodule // sfe_buf2

// ### dv/sfe_host_model.sv
// Host serial master model: chip select, serial clock, data lines.
// Assumes clk_sys of 50 ns; half a serial period is four clk_sys cycles.
module sfe_host_model (
  // System
  input wire logic clk_sys,
  // Link
  output logic cs_n,
  output logic sck,
  output logic [3:0] h_out,
  output logic [3:0] h_oe,
  input wire logic [3:0] io
);
  timeunit 1ns;
  timeprecision 1ns;
  logic idle_lvl = 1'b0;
  // Deselected and released at time zero
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    h_out = 4'h0;
    h_oe = 4'h0;
  end
  task automatic half();
    repeat (4) @(posedge clk_sys);
  endtask
  // select in mode 0 or 3
  task automatic start(input logic cpol);
    @(posedge clk_sys);
    idle_lvl = cpol;
    sck <= cpol;
    half();
    cs_n <= 1'b0;
    half();
  endtask
  // change on fall, top bits first
  task automatic put(input logic [31:0] v, input int n, input int w);
    for (int i = n - 1; i >= 0; i--) begin
      sck <= 1'b0;
      h_oe <= 4'((1 << w) - 1);
      h_out <= 4'(v >> (i * w));
      half();
      sck <= 1'b1;
      half();
    end
  endtask
  // released; sampled late in the high half for margin
  task automatic get(input int n, input int w, output logic [31:0] r);
    r = 32'h0;
    for (int i = 0; i < n; i++) begin
      sck <= 1'b0;
      h_oe <= 4'h0;
      half();
      sck <= 1'b1;
      repeat (3) @(posedge clk_sys);
      r = (r << w) | 32'(w == 1 ? 4'(io[1]) : io & 4'((1 << w) - 1));
      @(posedge clk_sys);
    end
  endtask
  // clock back to idle, then deselect
  task automatic stop();
    sck <= idle_lvl;
    h_oe <= 4'h0;
    half();
    cs_n <= 1'b1;
    half();
    half();
  endtask
endmodule // sfe_host_model

// ### dv/test_serial_flash_command_front_end.sv
// Bench for the command front end with a host model on the pins.
// Assumes the model drives the link; bench feeds read data, drains writes.
module test_serial_flash_command_front_end import sfe_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst;
  logic cs_n, sck, cmd_valid, tx_req, rx_valid, rx_overrun;
  logic rx_ready;
  logic [3:0] h_out, h_oe, io_in, io_out, io_oe;
  logic [3:0] noise = 4'h0;
  logic [7:0] tx_data;
  // Restarts the read-data count; the source process alone drives tx_data
  logic tx_clr;
  logic [7:0] rx_data;
  sfe_cmd_t cmd, last_cmd;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n_cmd = 0;
  logic [7:0] rxq [$];
  always #25 clk_sys = ~clk_sys;
  // Undriven lines wander so a stale level never passes
  assign io_in = (io_oe & io_out) | (~io_oe & h_oe & h_out) | (~io_oe & ~h_oe & noise);
  sfe_host_model h (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .h_out(h_out), .h_oe(h_oe),
    .io(io_in));
  sfe_front_end dut (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sck(sck), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .cmd(cmd), .cmd_valid(cmd_valid), .tx_req(tx_req),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .rx_overrun(rx_overrun));
  // Data source, sink, report capture and hang limit
  always @(posedge clk_sys) begin
    noise <= noise + 4'h5;
    cycles <= cycles + 1;
    if (cmd_valid === 1'b1) begin
      last_cmd <= cmd;
      n_cmd <= n_cmd + 1;
    end
    if (tx_clr === 1'b1) begin
      tx_data <= 8'h00;
    end else if (tx_req === 1'b1) begin
      tx_data <= tx_data + 8'h35;
    end
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
    if (cycles == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One read of the given shape, two bytes out
  task automatic rd(input logic [7:0] op, input logic cont, input int al, input int mc,
      input logic [7:0] mode, input int dc, input int dl, input logic cpol);
    logic [31:0] r;
    int n0;
    n0 = n_cmd;
    @(posedge clk_sys);
    tx_clr <= 1'b1;
    @(posedge clk_sys);
    tx_clr <= 1'b0;
    h.start(cpol);
    if (!cont) h.put(32'(op), 8, 1);
    h.put(32'h00d23456, 24 / al, al);
    if (mc > 0) h.put(32'(mode), mc, al);
    if (dc > 0) h.get(dc, 1, r);
    chk(32'(io_oe), 32'h0, "drive before data");
    h.get(8 / dl, dl, r);
    chk(32'(io_oe), 32'(dl == 1 ? OE_X1 : dl == 2 ? OE_X2 : OE_X4), "enables");
    chk(r, 32'h35, "byte 0");
    h.get(8 / dl, dl, r);
    chk(r, 32'h6a, "byte 1");
    h.stop();
    chk(n_cmd - n0, 1, "reports");
    chk(32'(last_cmd.opcode), 32'(op), "opcode");
    chk(32'(last_cmd.addr), 32'h523456, "address");
    if (mc > 0) chk(32'(last_cmd.mode), 32'(mode), "mode");
    if (mc > 0) chk(32'(last_cmd.cont), 32'(mode == MODE_CONT), "cont flag");
  endtask
  task automatic t_reads();
    rd(OP_READ, 1'b0, 1, 0, 8'h00, 0, 1, 1'b0);
    rd(OP_READ, 1'b0, 1, 0, 8'h00, 0, 1, 1'b1);
    rd(OP_FREAD, 1'b0, 1, 0, 8'h00, 8, 1, 1'b0);
    rd(OP_DREAD, 1'b0, 1, 0, 8'h00, 8, 2, 1'b0);
    rd(OP_QREAD, 1'b0, 1, 0, 8'h00, 8, 4, 1'b0);
    rd(OP_QIO, 1'b0, 4, 2, 8'h00, 4, 4, 1'b0);
    rd(OP_QWORD, 1'b0, 4, 2, 8'h00, 2, 4, 1'b0);
  endtask
  // Enter continuous, read without opcode, leave, then need an opcode
  task automatic t_cont();
    rd(OP_DIO, 1'b0, 2, 4, MODE_CONT, 0, 2, 1'b0);
    rd(OP_DIO, 1'b1, 2, 4, 8'h00, 0, 2, 1'b0);
    rd(OP_READ, 1'b0, 1, 0, 8'h00, 0, 1, 1'b0);
    rd(OP_QIO, 1'b0, 4, 2, MODE_CONT, 4, 4, 1'b0);
    rd(OP_QIO, 1'b1, 4, 2, 8'h00, 4, 4, 1'b0);
  endtask
  task automatic t_opc();
    logic [7:0] ops [7] = '{OP_RST_ARM, OP_RST_GO, OP_SLEEP, OP_WAKE, OP_WEN, OP_VWEN, OP_WDIS};
    logic [31:0] r;
    int n0;
    foreach (ops[i]) begin
      n0 = n_cmd;
      h.start(1'b0);
      h.put(32'(ops[i]), 8, 1);
      h.get(16, 1, r);
      chk(32'(io_oe), 32'h0, "no drive");
      h.stop();
      chk(n_cmd - n0, 1, "reports");
      chk(32'(last_cmd.opcode), 32'(ops[i]), "opcode");
    end
  endtask
  // Unknown opcode, then a deselect inside the address
  task automatic t_refuse();
    logic [31:0] r;
    int n0;
    n0 = n_cmd;
    h.start(1'b0);
    h.put(32'h20, 8, 1);
    h.put(32'h0b123456, 32, 1);
    h.get(16, 1, r);
    chk(32'(io_oe), 32'h0, "ignored drive");
    h.stop();
    h.start(1'b0);
    h.put(32'(OP_READ), 8, 1);
    h.put(32'h1234, 16, 1);
    h.stop();
    chk(n_cmd - n0, 0, "no report");
    rd(OP_READ, 1'b0, 1, 0, 8'h00, 0, 1, 1'b0);
  endtask
  // Write bytes with the sink stalled, then quad program and wrap setup
  task automatic t_prog();
    logic [31:0] r;
    rx_ready <= 1'b0;
    h.start(1'b0);
    h.put(32'(OP_PROG), 8, 1);
    h.put(32'h00a1b2c3, 24, 1);
    h.put(32'h00a1b2c3, 24, 1);
    h.stop();
    chk(32'(rx_overrun), 32'h1, "overrun");
    rx_ready <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(32'({rxq.size(), rxq[0], rxq[1]}), 32'h2a1b2, "drained");
    chk(32'(rx_valid), 32'h0, "empty");
    rxq.delete();
    h.start(1'b0);
    h.put(32'(OP_QPROG), 8, 1);
    h.put(32'h0, 24, 1);
    h.put(32'h5ac3, 4, 4);
    h.stop();
    chk(32'(rx_overrun), 32'h0, "overrun cleared");
    h.start(1'b0);
    h.put(32'(OP_WRAP), 8, 1);
    h.get(6, 1, r);
    h.put(32'h70, 2, 4);
    h.stop();
    chk(32'({rxq.size(), rxq[0], rxq[1], rxq[2]}), 32'h35ac370, "quad bytes");
  endtask
  initial begin
    rst <= 1'b1;
    rx_ready <= 1'b1;
    tx_clr <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_reads();
    t_cont();
    t_opc();
    t_refuse();
    t_prog();
    give_verdict();
  end
endmodule // test_serial_flash_command_front_end
